//--- src/mcr_pkg.sv
// Package: register map, field layout and timing of the calibration and result bank
package mcr_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int DW = 32;
  localparam int AW = 10;
  localparam int NUM_RW = 20;
  localparam int NUM_THR = 5;
  localparam int NUM_PH = 3;

  // ----------------------------------------
  // Read-write register offsets, by storage index
  // ----------------------------------------
  localparam int IX_C_VAR_OS = 0;
  localparam int IX_C_FVAR_OS = 1;
  localparam int IX_CFG0 = 2;
  localparam int IX_THR_LO = 3;
  localparam int IX_THR_HI = 8;
  localparam int IX_N_RMS_OS = 13;
  localparam int IX_ISUM_OS = 14;
  localparam int IX_N_GAIN = 15;
  localparam int IX_N_PHASE = 16;
  localparam int IX_V_NOM = 17;
  localparam int IX_INT_COEFF = 18;
  localparam int IX_ISUM_LVL = 19;
  localparam logic [NUM_RW-1:0][AW-1:0] RW_OFS = {
    10'h073, 10'h072, 10'h071, 10'h06e, 10'h06d, 10'h06c, 10'h06b,
    10'h06a, 10'h069, 10'h068, 10'h067, 10'h066,
    10'h065, 10'h064, 10'h063, 10'h062, 10'h061,
    10'h060, 10'h052, 10'h050};
  localparam logic [NUM_RW-1:0][DW-1:0] RW_RST = '0;

  // ----------------------------------------
  // Read-only results and own registers
  // ----------------------------------------
  localparam logic [AW-1:0] OFS_PHA_I_WAVE = 10'h20a;
  localparam logic [AW-1:0] OFS_PHA_V_WAVE = 10'h20b;
  localparam logic [AW-1:0] OFS_PHA_I_RMS = 10'h20c;
  localparam logic [AW-1:0] OFS_PHA_V_RMS = 10'h20d;
  localparam logic [AW-1:0] OFS_PHA_WATT = 10'h210;
  localparam logic [AW-1:0] OFS_STATUS_WORD_ZERO = 10'h3f0;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 10'h3f1;
  localparam logic [DW-1:0] RES_RST = 32'h00000000;

  // ----------------------------------------
  // Fields
  // ----------------------------------------
  localparam int CFG_MT_EN = 0;
  localparam int CFG_I_INT_EN = 1;
  localparam int CFG_N_INT_EN = 2;
  localparam int CFG_NOMINAL_VOLTAGE_RMS_SEL = 3;
  localparam int ST_MISMATCH = 0;
  localparam logic [3:0] MT_REGION_RST = 4'hf;
  localparam int GAIN_FRAC = 23;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint CLK_HZ = 200000000;
  localparam longint SAMPLE_RATE_HZ = 4000;
  localparam int SAMPLE_CYCLES = int'(CLK_HZ / SAMPLE_RATE_HZ);

endpackage

//--- src/mcr_mp_if.sv
// Interface: link between the bank and each multipoint region tracker
`timescale 1ns/10ps
`default_nettype none
interface mcr_mp_if;
  import mcr_pkg::*;
  logic tick;
  logic en;
  logic [DW-1:0] irms;
  logic [NUM_THR-1:0][DW-1:0] lo;
  logic [NUM_THR-1:0][DW-1:0] hi;
  logic [3:0] region;
  modport ctl (output tick, en, irms, lo, hi, input region);
  modport trk (input tick, en, irms, lo, hi, output region);
endinterface
`default_nettype wire

//--- src/mcr_mp_track.sv
// Multipoint correction-set tracker with hysteresis for one phase
`timescale 1ns/10ps
`default_nettype none
module mcr_mp_track
  import mcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Thresholds, current and region
  mcr_mp_if.trk mp
);

  // ----------------------------------------
  // Region state
  // ----------------------------------------
  logic [2:0] set_ff;
  logic [2:0] nxt_set;
  logic [3:0] region_ff;

  // One step per sample keeps a noisy current from skipping sets
  always_comb begin
    nxt_set = set_ff;
    if (mp.irms > mp.hi[set_ff] && set_ff < 3'(NUM_THR - 1)) begin
      nxt_set = set_ff + 3'd1;
    end else if (mp.irms < mp.lo[set_ff] && set_ff != 3'd0) begin
      nxt_set = set_ff - 3'd1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      set_ff <= 3'd0;
    end else if (!mp.en) begin
      set_ff <= 3'd0;
    end else if (mp.tick) begin
      set_ff <= nxt_set;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      region_ff <= MT_REGION_RST;
    end else begin
      region_ff <= mp.en ? {1'b0, set_ff} : MT_REGION_RST;
    end
  end

  assign mp.region = region_ff;

endmodule
`default_nettype wire

//--- src/mcr_regs.sv
// Calibration, configuration and phase A result register bank
//
// Notes on behaviour
// - Multipoint enable makes the low/high thresholds pick the correction set.
// - Sets switch with hysteresis: up above high, down below low threshold.
// - Nominal-voltage select feeds programmed nominal voltage to apparent power.
// - Integrator runs when current or neutral integrator enable is one.
// - Current-sum rms above mismatch level sets mismatch flag in status zero.
// - Current-sum offset corrects the rms of the summed currents.
// - Phase C total reactive offset is added to total reactive power.
// - Phase C fundamental reactive offset corrects fundamental reactive power.
// - Neutral rms offset corrects the neutral current rms.
// - Neutral gain scales neutral samples; neutral phase trim goes to the filter.
// - Phase A current and voltage waveforms refresh at 4 kSPS.
// - Phase A current and voltage rms refresh at 4 kSPS.
// - Phase A filtered active power refreshes at 4 kSPS.
// - Each phase picks its set from its own current rms against the shared thresholds.
// - Multipoint disabled: first phase trim only, no extra gain factor.
`timescale 1ns/10ps
`default_nettype none
module mcr_regs
  import mcr_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  // Raw results from the signal path
  input wire logic [DW-1:0] dsp_ia_wave,
  input wire logic [DW-1:0] dsp_va_wave,
  input wire logic [DW-1:0] dsp_ia_rms,
  input wire logic [DW-1:0] dsp_va_rms,
  input wire logic [DW-1:0] dsp_pa_watt,
  input wire logic [NUM_PH-1:0][DW-1:0] dsp_i_rms,
  input wire logic [DW-1:0] dsp_c_var,
  input wire logic [DW-1:0] dsp_c_fvar,
  input wire logic [DW-1:0] dsp_n_rms,
  input wire logic [DW-1:0] dsp_isum_rms,
  input wire logic [DW-1:0] dsp_n_sample,
  // Corrected results
  output logic sample_tick,
  output logic [DW-1:0] c_var_corr,
  output logic [DW-1:0] c_fvar_corr,
  output logic [DW-1:0] n_rms_corr,
  output logic [DW-1:0] isum_rms_corr,
  output logic [DW-1:0] n_sample_scaled,
  output logic [DW-1:0] va_voltage,
  // Controls to the signal path
  output logic [DW-1:0] n_phase_comp,
  output logic integrator_run,
  output logic [DW-1:0] integrator_coeff,
  output logic mt_gain_extra_en,
  output logic [NUM_PH-1:0][3:0] mt_region,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Sample tick
  // ----------------------------------------
  logic [31:0] div_ff;
  logic tick_ff;

  // Free-running divider, one tick per output sample
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= 32'h00000000;
    end else if (div_ff == 32'(SAMPLE_DIV - 1)) begin
      div_ff <= 32'h00000000;
    end else begin
      div_ff <= div_ff + 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == 32'(SAMPLE_DIV - 1));
    end
  end

  assign sample_tick = tick_ff;

  // ----------------------------------------
  // Read-write bank
  // ----------------------------------------
  logic [NUM_RW-1:0][DW-1:0] rw_ff;
  logic [NUM_RW-1:0] rw_hit;

  always_comb begin
    for (int i = 0; i < NUM_RW; i++) begin
      rw_hit[i] = (reg_addr == RW_OFS[i]);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rw_ff <= RW_RST;
    end else if (reg_wr) begin
      for (int i = 0; i < NUM_RW; i++) begin
        if (rw_hit[i]) begin
          rw_ff[i] <= reg_wdata;
        end
      end
    end
  end

  logic [DW-1:0] cfg0;
  assign cfg0 = rw_ff[IX_CFG0];

  // ----------------------------------------
  // Controls to the signal path
  // ----------------------------------------
  // Coefficient passes as written; 0xffffe000 is left to software
  assign integrator_coeff = rw_ff[IX_INT_COEFF];
  assign integrator_run = cfg0[CFG_I_INT_EN] | cfg0[CFG_N_INT_EN];
  assign n_phase_comp = rw_ff[IX_N_PHASE];
  assign mt_gain_extra_en = cfg0[CFG_MT_EN];

  // ----------------------------------------
  // Multipoint region trackers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_PH; g++) begin : g_mp
      mcr_mp_if mpi ();
      assign mpi.tick = tick_ff;
      assign mpi.en = cfg0[CFG_MT_EN];
      assign mpi.irms = dsp_i_rms[g];
      for (genvar t = 0; t < NUM_THR; t++) begin : g_thr
        assign mpi.lo[t] = rw_ff[IX_THR_LO + t];
        assign mpi.hi[t] = rw_ff[IX_THR_HI + t];
      end
      mcr_mp_track u_trk (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .mp(mpi.trk)
      );
      assign mt_region[g] = mpi.region;
    end
  endgenerate

  // ----------------------------------------
  // Corrected results
  // ----------------------------------------
  logic [DW-1:0] c_var_ff;
  logic [DW-1:0] c_fvar_ff;
  logic [DW-1:0] n_rms_ff;
  logic [DW-1:0] isum_ff;
  logic [DW-1:0] n_scaled_ff;
  logic [DW-1:0] va_volt_ff;
  logic [DW-1:0] nxt_isum;
  logic signed [2*DW-1:0] n_prod;

  assign nxt_isum = dsp_isum_rms + rw_ff[IX_ISUM_OS];
  // Gain is a signed fraction, so zero leaves the channel untouched
  assign n_prod = $signed(dsp_n_sample) * $signed(rw_ff[IX_N_GAIN]);

  // Offsets wrap modulo 2^32, so a negative trim is its two's complement
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      c_var_ff <= RES_RST;
    end else if (tick_ff) begin
      c_var_ff <= dsp_c_var + rw_ff[IX_C_VAR_OS];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      c_fvar_ff <= RES_RST;
    end else if (tick_ff) begin
      c_fvar_ff <= dsp_c_fvar + rw_ff[IX_C_FVAR_OS];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      n_rms_ff <= RES_RST;
    end else if (tick_ff) begin
      n_rms_ff <= dsp_n_rms + rw_ff[IX_N_RMS_OS];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      isum_ff <= RES_RST;
    end else if (tick_ff) begin
      isum_ff <= nxt_isum;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      n_scaled_ff <= RES_RST;
    end else if (tick_ff) begin
      n_scaled_ff <= dsp_n_sample + n_prod[GAIN_FRAC +: DW];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      va_volt_ff <= RES_RST;
    end else if (tick_ff) begin
      va_volt_ff <= cfg0[CFG_NOMINAL_VOLTAGE_RMS_SEL] ? rw_ff[IX_V_NOM] : dsp_va_rms;
    end
  end

  assign c_var_corr = c_var_ff;
  assign c_fvar_corr = c_fvar_ff;
  assign n_rms_corr = n_rms_ff;
  assign isum_rms_corr = isum_ff;
  assign n_sample_scaled = n_scaled_ff;
  assign va_voltage = va_volt_ff;

  // ----------------------------------------
  // Phase A read-only results
  // ----------------------------------------
  logic [DW-1:0] pa_i_wave_ff;
  logic [DW-1:0] pa_v_wave_ff;
  logic [DW-1:0] pa_i_rms_ff;
  logic [DW-1:0] pa_v_rms_ff;
  logic [DW-1:0] pa_watt_ff;

  // Snapshot on the tick so a read never sees a half-updated set
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pa_i_wave_ff <= RES_RST;
      pa_v_wave_ff <= RES_RST;
    end else if (tick_ff) begin
      pa_i_wave_ff <= dsp_ia_wave;
      pa_v_wave_ff <= dsp_va_wave;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pa_i_rms_ff <= RES_RST;
      pa_v_rms_ff <= RES_RST;
    end else if (tick_ff) begin
      pa_i_rms_ff <= dsp_ia_rms;
      pa_v_rms_ff <= dsp_va_rms;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pa_watt_ff <= RES_RST;
    end else if (tick_ff) begin
      pa_watt_ff <= dsp_pa_watt;
    end
  end

  // ----------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------
  logic mismatch_ff;
  logic mask_ff;
  logic irq_ff;
  logic mis_set;
  logic mis_clr;

  // Compared with the fresh sum so the flag lines up with the result
  assign mis_set = tick_ff && (nxt_isum > rw_ff[IX_ISUM_LVL]);
  assign mis_clr = reg_wr && (reg_addr == OFS_STATUS_WORD_ZERO) && reg_wdata[ST_MISMATCH];

  // Set beats a same-cycle clear so no event is lost
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mismatch_ff <= 1'b0;
    end else if (mis_set) begin
      mismatch_ff <= 1'b1;
    end else if (mis_clr) begin
      mismatch_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mask_ff <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
      mask_ff <= reg_wdata[ST_MISMATCH];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= mismatch_ff & mask_ff;
    end
  end

  assign irq = irq_ff;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [DW-1:0] rdata_ff;
  logic [DW-1:0] nxt_rdata;

  // Unmapped offsets read as zero
  always_comb begin
    nxt_rdata = '0;
    for (int i = 0; i < NUM_RW; i++) begin
      if (rw_hit[i]) begin
        nxt_rdata = rw_ff[i];
      end
    end
    unique case (reg_addr)
      OFS_PHA_I_WAVE: nxt_rdata = pa_i_wave_ff;
      OFS_PHA_V_WAVE: nxt_rdata = pa_v_wave_ff;
      OFS_PHA_I_RMS: nxt_rdata = pa_i_rms_ff;
      OFS_PHA_V_RMS: nxt_rdata = pa_v_rms_ff;
      OFS_PHA_WATT: nxt_rdata = pa_watt_ff;
      OFS_STATUS_WORD_ZERO: nxt_rdata[ST_MISMATCH] = mismatch_ff;
      OFS_IRQ_MASK: nxt_rdata[ST_MISMATCH] = mask_ff;
      default: ;
    endcase
  end

  // Data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

//--- verification/mcr_regs_props.sv
// Checker: port-level properties of the calibration and result bank
`timescale 1ns/10ps
`default_nettype none
module mcr_regs_props
  import mcr_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DW-1:0] reg_rdata,
  // Watched outputs
  input wire logic sample_tick,
  input wire logic [DW-1:0] c_var_corr,
  input wire logic [DW-1:0] va_voltage,
  input wire logic [DW-1:0] n_phase_comp,
  input wire logic integrator_run,
  input wire logic [DW-1:0] integrator_coeff,
  input wire logic mt_gain_extra_en,
  input wire logic [NUM_PH-1:0][3:0] mt_region,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic cfg_wr;
  assign cfg_wr = reg_wr && reg_addr == RW_OFS[IX_CFG0];
  // Cycles since the last tick, restarted by reset like the divider
  logic [31:0] since_tick_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      since_tick_ff <= 32'h00000000;
    end else if (sample_tick) begin
      since_tick_ff <= 32'h00000001;
    end else begin
      since_tick_ff <= since_tick_ff + 32'h00000001;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its slot");
  chk_int_run: assert property (cfg_wr |=> integrator_run ==
    ($past(reg_wdata[CFG_I_INT_EN]) | $past(reg_wdata[CFG_N_INT_EN])))
    else $error("integrator run level wrong");
  chk_mt_enable: assert property (cfg_wr |=> mt_gain_extra_en == $past(reg_wdata[CFG_MT_EN]))
    else $error("multipoint enable wrong");
  chk_coeff_load: assert property (reg_wr && reg_addr == RW_OFS[IX_INT_COEFF]
    |=> integrator_coeff == $past(reg_wdata)) else $error("coefficient not loaded");
  chk_nphase_load: assert property (reg_wr && reg_addr == RW_OFS[IX_N_PHASE]
    |=> n_phase_comp == $past(reg_wdata)) else $error("neutral phase trim not loaded");
  chk_tick_gap: assert property (sample_tick |=> !sample_tick [*8])
    else $error("sample ticks too close");
  chk_result_hold: assert property (!$past(sample_tick)
    |-> $stable(c_var_corr) && $stable(va_voltage)) else $error("result moved off tick");
  chk_mt_off: assert property (!mt_gain_extra_en [*3] |-> mt_region == {NUM_PH{MT_REGION_RST}})
    else $error("region shown while multipoint off");
  chk_irq_rise: assert property ($rose(irq) |-> $past(sample_tick, 2) || $past(reg_wr, 2))
    else $error("interrupt rose without cause");
  chk_irq_fall: assert property ($fell(irq) |-> $past(reg_wr, 2))
    else $error("interrupt fell without write");
  chk_tick_period: assert property (sample_tick == (since_tick_ff == 32'(SAMPLE_DIV)))
    else $error("sample tick period wrong");
  cov_tick: cover property (sample_tick);
  cov_clr_tick: cover property (reg_wr && reg_addr == OFS_STATUS_WORD_ZERO && sample_tick);
  cov_irq: cover property ($rose(irq));
  cov_region: cover property (mt_region[0] == 4'h1);
endmodule
bind mcr_regs mcr_regs_props #(.SAMPLE_DIV(SAMPLE_DIV)) i_props (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(sample_tick),
  .c_var_corr(c_var_corr), .va_voltage(va_voltage), .n_phase_comp(n_phase_comp),
  .integrator_run(integrator_run), .integrator_coeff(integrator_coeff),
  .mt_gain_extra_en(mt_gain_extra_en), .mt_region(mt_region), .irq(irq));
`default_nettype wire

//--- verification/mcr_host.sv
// Host model: software master on the register port
`timescale 1ns/10ps
`default_nettype none
module mcr_host
  import mcr_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [AW-1:0] reg_addr,
  output logic [DW-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [DW-1:0] reg_rdata
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // Idle bus shows inverted values, never a stale word
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
  // Integrating mode always loads the recommended coefficient first
  task automatic int_on(input logic [DW-1:0] cfg);
    wr(RW_OFS[IX_INT_COEFF], 32'hffffe000);
    wr(RW_OFS[IX_CFG0], cfg);
  endtask
endmodule
`default_nettype wire

//--- verification/mcr_regs_tb.sv
// Testbench: register bank, results, interrupt and multipoint tracking
`timescale 1ns/10ps
`default_nettype none
module mcr_regs_tb;
  import mcr_pkg::*;
  localparam int DIV = 16;
  localparam logic [AW+2*DW-1:0] ROWS [7] = '{
    {10'h050, 32'ha5a50001, 32'ha5a50001}, {10'h052, 32'h80000000, 32'h80000000},
    {10'h06a, 32'hffffffff, 32'hffffffff}, {10'h06e, 32'h12345678, 32'h12345678},
    {10'h073, 32'h00000100, 32'h00000100}, {10'h20a, 32'hdeadbeef, 32'h00000000},
    {10'h100, 32'hffffffff, 32'h00000000}};
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, rdv;
  logic reg_wr, reg_rd, sample_tick, integrator_run, mt_en, irq;
  logic [DW-1:0] ia_w = '0, va_w = '0, ia_r = '0, va_r = '0, pa_w = '0, c_var = '0;
  logic [DW-1:0] c_fvar = '0, n_rms = '0, isum = '0, n_smp = '0;
  logic [NUM_PH-1:0][DW-1:0] i_rms = '0;
  logic [DW-1:0] c_var_c, c_fvar_c, n_rms_c, isum_c, n_scl, va_v, n_ph, coeff;
  logic [NUM_PH-1:0][3:0] region;
  int num_errors = 0;
  int checks_done = 0;
  int tick_n;
  always #2.5 clk_sys = ~clk_sys;
  mcr_host i_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  mcr_regs #(.SAMPLE_DIV(DIV)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dsp_ia_wave(ia_w), .dsp_va_wave(va_w), .dsp_ia_rms(ia_r),
    .dsp_va_rms(va_r), .dsp_pa_watt(pa_w), .dsp_i_rms(i_rms), .dsp_c_var(c_var),
    .dsp_c_fvar(c_fvar), .dsp_n_rms(n_rms), .dsp_isum_rms(isum), .dsp_n_sample(n_smp),
    .sample_tick(sample_tick), .c_var_corr(c_var_c), .c_fvar_corr(c_fvar_c),
    .n_rms_corr(n_rms_c), .isum_rms_corr(isum_c), .n_sample_scaled(n_scl),
    .va_voltage(va_v), .n_phase_comp(n_ph), .integrator_run(integrator_run),
    .integrator_coeff(coeff), .mt_gain_extra_en(mt_en), .mt_region(region), .irq(irq));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    i_host.rd(a, rdv);
    chk(rdv, exp);
  endtask
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Waits past a tick edge plus three cycles, so region lag has settled too
  task automatic tick();
    tick_n = 0;
    while (sample_tick !== 1'b1 && tick_n < 100) begin
      @(posedge clk_sys);
      #1;
      tick_n++;
    end
    if (tick_n >= 100) begin
      num_errors++;
      conclude();
    end
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < NUM_RW; i++) rdc(RW_OFS[i], RW_RST[i]);
    chk(region, {NUM_PH{MT_REGION_RST}});
    for (int i = 0; i < 7; i++) i_host.wr(ROWS[i][73:64], ROWS[i][63:32]);
    for (int i = 0; i < 7; i++) rdc(ROWS[i][73:64], ROWS[i][31:0]);
    chk(n_ph, 32'h12345678);
    for (int i = 0; i < 4; i++) begin
      i_host.int_on(DW'(i << 1));
      #1;
      chk(integrator_run, DW'(i != 0));
    end
    chk(coeff, 32'hffffe000);
    i_host.wr(RW_OFS[IX_C_VAR_OS], 32'h2);
    i_host.wr(RW_OFS[IX_C_FVAR_OS], 32'hffffffff);
    i_host.wr(RW_OFS[IX_N_RMS_OS], 32'h3);
    i_host.wr(RW_OFS[IX_ISUM_OS], 32'h10);
    i_host.wr(RW_OFS[IX_N_GAIN], 32'h00400000);
    i_host.wr(RW_OFS[IX_V_NOM], 32'h1111);
    i_host.wr(RW_OFS[IX_CFG0], 32'h8);
    i_host.wr(OFS_IRQ_MASK, 32'h1);
    @(posedge clk_sys);
    c_var <= 32'h5;
    n_rms <= 32'h7;
    isum <= 32'hf0;
    n_smp <= 32'h100;
    {ia_w, va_w, ia_r, va_r, pa_w} <= {32'h11, 32'h12, 32'h13, 32'h14, 32'h15};
    tick();
    chk(c_var_c, 32'h7);
    chk(c_fvar_c, 32'hffffffff);
    chk(n_rms_c, 32'ha);
    chk(isum_c, 32'h100);
    chk(n_scl, 32'h180);
    chk(va_v, 32'h1111);
    rdc(OFS_STATUS_WORD_ZERO, 32'h0);
    rdc(OFS_PHA_I_WAVE, 32'h11);
    rdc(OFS_PHA_V_WAVE, 32'h12);
    rdc(OFS_PHA_I_RMS, 32'h13);
    rdc(OFS_PHA_V_RMS, 32'h14);
    rdc(OFS_PHA_WATT, 32'h15);
    isum <= 32'hf1;
    tick();
    isum <= 32'h0;
    chk(irq, 32'h1);
    rdc(OFS_STATUS_WORD_ZERO, 32'h1);
    // Interrupt is registered, so it follows mask and flag one edge later
    i_host.wr(OFS_IRQ_MASK, 32'h0);
    @(posedge clk_sys);
    #1;
    chk(irq, 32'h0);
    i_host.wr(OFS_IRQ_MASK, 32'h1);
    @(posedge clk_sys);
    #1;
    chk(irq, 32'h1);
    i_host.wr(OFS_STATUS_WORD_ZERO, 32'h1);
    @(posedge clk_sys);
    #1;
    chk(irq, 32'h0);
    i_host.wr(RW_OFS[IX_THR_HI], 32'd100);
    i_host.wr(RW_OFS[IX_THR_LO + 1], 32'd50);
    i_host.wr(RW_OFS[IX_THR_HI + 1], 32'd200);
    i_rms <= {32'd150, 32'd10, 32'd150};
    i_host.wr(RW_OFS[IX_CFG0], 32'h1);
    tick();
    chk(mt_en, 32'h1);
    chk(region, {4'h1, 4'h0, 4'h1});
    chk(va_v, 32'h14);
    i_rms[0] <= 32'd80;
    tick();
    chk(region, {4'h1, 4'h0, 4'h1});
    i_rms[0] <= 32'd40;
    tick();
    chk(region, {4'h1, 4'h0, 4'h0});
    tick();
    chk(DW'(tick_n), DW'(DIV - 3));
    // Clear lands on a tick edge with a fresh mismatch: the set must win
    isum <= 32'hf1;
    tick();
    repeat (DIV - 4) @(posedge clk_sys);
    i_host.wr(OFS_STATUS_WORD_ZERO, 32'h1);
    isum <= 32'h0;
    rdc(OFS_STATUS_WORD_ZERO, 32'h1);
    chk(irq, 32'h1);
    i_host.wr(OFS_STATUS_WORD_ZERO, 32'h1);
    rdc(OFS_STATUS_WORD_ZERO, 32'h0);
    i_host.wr(RW_OFS[IX_CFG0], 32'h0);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(region, {NUM_PH{MT_REGION_RST}});
    arst_n <= 1'b0;
    @(negedge clk_sys);
    chk(coeff, 32'h0);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    rdc(RW_OFS[IX_V_NOM], 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
